/* clk_ctrl.sv */
// Clock control block: write protection, oscillators, pin mux, prescaler.
`timescale 1ns/100ps
module clk_ctrl
  import clk_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic cold_start,
  input wire logic sleep_mode,
  input wire logic slow_oscillator,
  input wire logic dram_read_strobe_n,
  input wire logic port_data,
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic shared_output_pin,
  output logic slow_osc_en,
  output logic fast_osc_en,
  output logic cpu_clk_src_sel,
  output logic feedback_res_off,
  output logic [NUM_PERIPH_CLK-1:0] periph_tick
);

  logic [7:0] power_control;
  logic [7:0] clock_option;
  logic [7:0] protect_key;
  logic [7:0] low_speed_osc_control;
  logic [7:0] periph_clk [NUM_PERIPH_CLK];
  logic pin_clkout_sel;
  logic pin_ext_sel;
  logic unlocked;
  logic prot_wr;
  logic [7:0] next_power;
  logic [4*NUM_PERIPH_CLK-1:0] periph_cfg;
  logic [NUM_PERIPH_CLK-1:0] tick_raw;
  pin_func_type pin_func;
  reg_req_type req;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign unlocked = (protect_key == PROTECT_UNLOCK_KEY);
  assign prot_wr = req.wr && (req.addr == POWER_CONTROL_ADDR ||
    req.addr == CLOCK_OPTION_ADDR);

  // Merge a write into a register under its writable mask.
  function automatic logic [7:0] merge(input logic [7:0] old,
    input logic [7:0] val, input logic [7:0] mask);
    merge = (old & ~mask) | (val & mask);
  endfunction

  // ************************************************************************
  // Guarded power control update
  // ************************************************************************
  always_comb begin
    next_power = merge(power_control, req.wdata, POWER_CONTROL_WMASK);
    // Stopping the oscillator that feeds the CPU is refused.
    if (power_control[CPU_CLK_SRC_SEL_BIT] &&
        !next_power[FAST_OSC_EN_BIT]) begin
      next_power[FAST_OSC_EN_BIT] = 1'b1;
    end
    if (!power_control[CPU_CLK_SRC_SEL_BIT] &&
        !next_power[SLOW_OSC_EN_BIT]) begin
      next_power[SLOW_OSC_EN_BIT] = 1'b1;
    end
    // The source may change only while both oscillators run.
    if (!(power_control[FAST_OSC_EN_BIT] &&
          power_control[SLOW_OSC_EN_BIT])) begin
      next_power[CPU_CLK_SRC_SEL_BIT] =
        power_control[CPU_CLK_SRC_SEL_BIT];
    end
  end

  // ************************************************************************
  // Protection key
  // ************************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      protect_key <= PROTECT_KEY_RESET;
    end else if (clk_en) begin
      if (req.wr && req.addr == PROTECT_KEY_ADDR) begin
        protect_key <= req.wdata;
      end else if (prot_wr) begin
        protect_key <= PROTECT_KEY_RESET;
      end
    end
  end

  // ************************************************************************
  // Protected registers
  // ************************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      power_control <= POWER_CONTROL_RESET;
      clock_option <= CLOCK_OPTION_RESET;
    end else if (clk_en) begin
      if (prot_wr && unlocked) begin
        if (req.addr == POWER_CONTROL_ADDR) begin
          power_control <= next_power;
        end else begin
          clock_option <= merge(clock_option, req.wdata,
            CLOCK_OPTION_WMASK);
        end
      end
    end
  end

  // ************************************************************************
  // Unprotected control registers
  // ************************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_speed_osc_control <= LOW_SPEED_OSC_RESET;
      for (int i = 0; i < NUM_PERIPH_CLK; i++) begin
        periph_clk[i] <= PERIPH_CLK_RESET;
      end
    end else if (clk_en) begin
      if (req.wr && req.addr == LOW_SPEED_OSC_CONTROL_ADDR) begin
        low_speed_osc_control <= merge(low_speed_osc_control, req.wdata,
          LOW_SPEED_OSC_WMASK);
      end
      for (int i = 0; i < NUM_PERIPH_CLK; i++) begin
        if (req.wr && req.addr == PERIPH_CLK_BASE_ADDR + 20'(i)) begin
          periph_clk[i] <= req.wdata & 8'h7f;
        end
      end
    end
  end

  // ************************************************************************
  // Pin function bits, cleared only on cold start
  // ************************************************************************
  always_ff @(posedge clk) begin
    if (clk_en) begin
      if (cold_start) begin
        pin_clkout_sel <= 1'b0;
        pin_ext_sel <= 1'b0;
      end else begin
        if (req.wr && req.addr == OUTPUT_PIN_FUNCTION_SELECT_ADDR) begin
          pin_clkout_sel <= req.wdata[PIN_CLKOUT_SEL_BIT];
        end
        if (req.wr && req.addr == PORT_FUNCTION_EXTENSION_ADDR) begin
          pin_ext_sel <= req.wdata[PIN_EXT_SEL_BIT];
        end
      end
    end
  end

  // ************************************************************************
  // Register read port
  // ************************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      rdata <= 8'h00;
      if (req.rd) begin
        if (req.addr == POWER_CONTROL_ADDR) begin
          rdata <= power_control;
        end else if (req.addr == CLOCK_OPTION_ADDR) begin
          rdata <= clock_option;
        end else if (req.addr == PROTECT_KEY_ADDR) begin
          rdata <= protect_key;
        end else if (req.addr == LOW_SPEED_OSC_CONTROL_ADDR) begin
          rdata <= low_speed_osc_control;
        end else if (req.addr >= PERIPH_CLK_BASE_ADDR &&
            req.addr < PERIPH_CLK_BASE_ADDR + 20'(NUM_PERIPH_CLK)) begin
          rdata <= periph_clk[4'(req.addr - PERIPH_CLK_BASE_ADDR)];
        end else if (req.addr == OUTPUT_PIN_FUNCTION_SELECT_ADDR ||
            req.addr == PORT_FUNCTION_EXTENSION_ADDR) begin
          rdata <= 8'h00;
        end
      end
    end
  end

  // ************************************************************************
  // Shared pin multiplexer
  // ************************************************************************
  always_comb begin
    if (pin_ext_sel) begin
      pin_func = pin_dram_strobe;
    end else if (pin_clkout_sel) begin
      pin_func = pin_slow_clk;
    end else begin
      pin_func = pin_port;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shared_output_pin <= 1'b1;
    end else if (clk_en) begin
      case (pin_func)
        pin_dram_strobe: shared_output_pin <= dram_read_strobe_n;
        pin_slow_clk: shared_output_pin <= slow_oscillator &&
          clock_option[SLOW_CLK_OUT_EN_BIT];
        default: shared_output_pin <= port_data;
      endcase
    end
  end

  // ************************************************************************
  // Oscillator and clock select outputs
  // ************************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slow_osc_en <= 1'b1;
      fast_osc_en <= 1'b1;
      cpu_clk_src_sel <= 1'b1;
      feedback_res_off <= 1'b0;
      periph_tick <= '0;
    end else if (clk_en) begin
      slow_osc_en <= power_control[SLOW_OSC_EN_BIT];
      fast_osc_en <= power_control[FAST_OSC_EN_BIT] && !sleep_mode;
      cpu_clk_src_sel <= power_control[CPU_CLK_SRC_SEL_BIT];
      feedback_res_off <= low_speed_osc_control[FEEDBACK_RES_OFF_BIT];
      periph_tick <= tick_raw;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PERIPH_CLK; i++) begin
      periph_cfg[4*i +: 4] = periph_clk[i][3:0];
    end
  end

  prescaler_div #(
    .NUM(NUM_PERIPH_CLK),
    .W(PRESCALER_W)
  ) prescaler_div_i (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .hold_reset(!power_control[FAST_OSC_EN_BIT] || sleep_mode),
    .src_run(power_control[PRESCALER_CLK_EN_BIT] &&
      power_control[CPU_CLK_SRC_SEL_BIT]),
    .periph_cfg(periph_cfg),
    .periph_tick(tick_raw)
  );

endmodule

/* clk_ctrl_pkg.sv */
// Register map, field positions and reset values of the clock control block.
// ****************************************************************************
// Overview of operation
// - Slow clock drives shared pin if enabled and pin is muxed to clock.
// - Slow clock output enable resets to zero; writing zero disables output.
// - Protected writes take effect only while key holds the unlock value.
// - Key clears to zero after one protected write; rewrite before each one.
// - Any other key value keeps protection; key register stays readable.
// - Key resets to zero so protected registers start locked.
// - Feedback resistor bit one disconnects it; zero, its reset, keeps it.
// - Write-only pin select: one slow clock, zero port; reads undefined.
// - Pin select clears on cold start and holds across hot start.
// - Pin extension bit one outputs DRAM strobe; else pin select decides.
// - Pin extension clears on cold start and holds across hot start.
// - Attempt to stop the oscillator feeding the CPU is ignored.
// - CPU clock source may change only while both oscillators run.
// - Fast-clock peripherals stop if fast oscillator off or CPU clock slow.
// - Prescaler divides fast clock per peripheral with own ratio and gate.
// - Prescaler held in reset while fast oscillator disabled or in sleep.
// - Selecting slow CPU clock stops the prescaler source clock.
// - Prescaler enable gates fast clock into prescaler; resets to one.
// - CPU clock select: one fast, zero slow; resets to one.
// ****************************************************************************
package clk_ctrl_pkg;

  localparam int ADDR_W = 20;

  localparam logic [19:0] POWER_CONTROL_ADDR = 20'h4_0140;
  localparam logic [19:0] PERIPH_CLK_BASE_ADDR = 20'h4_0147;
  localparam logic [19:0] CLOCK_OPTION_ADDR = 20'h4_0150;
  localparam logic [19:0] PROTECT_KEY_ADDR = 20'h4_015e;
  localparam logic [19:0] LOW_SPEED_OSC_CONTROL_ADDR = 20'h4_015f;
  localparam logic [19:0] OUTPUT_PIN_FUNCTION_SELECT_ADDR = 20'h4_02cc;
  localparam logic [19:0] PORT_FUNCTION_EXTENSION_ADDR = 20'h4_02d8;

  localparam int SLOW_OSC_EN_BIT = 0;
  localparam int FAST_OSC_EN_BIT = 1;
  localparam int CPU_CLK_SRC_SEL_BIT = 2;
  localparam int PRESCALER_CLK_EN_BIT = 5;
  localparam int SLOW_CLK_OUT_EN_BIT = 0;
  localparam int FEEDBACK_RES_OFF_BIT = 1;
  localparam int PIN_CLKOUT_SEL_BIT = 1;
  localparam int PIN_EXT_SEL_BIT = 2;

  localparam logic [7:0] PROTECT_UNLOCK_KEY = 8'h96;
  localparam logic [7:0] PROTECT_KEY_RESET = 8'h00;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h27;
  localparam logic [7:0] POWER_CONTROL_WMASK = 8'he7;
  localparam logic [7:0] CLOCK_OPTION_RESET = 8'h00;
  localparam logic [7:0] CLOCK_OPTION_WMASK = 8'h0d;
  localparam logic [7:0] LOW_SPEED_OSC_RESET = 8'h01;
  localparam logic [7:0] LOW_SPEED_OSC_WMASK = 8'h86;
  localparam logic [7:0] PERIPH_CLK_RESET = 8'h00;

  localparam int NUM_PERIPH_CLK = 9;
  localparam int PRESCALER_W = 12;

  typedef enum logic [1:0] {
    pin_port,
    pin_slow_clk,
    pin_dram_strobe
  } pin_func_type;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

endpackage

/* prescaler_div.sv */
// Divider chain that feeds gated, ratio-selected clock enables to peripherals.
`timescale 1ns/100ps
module prescaler_div
  import clk_ctrl_pkg::*;
#(
  parameter int NUM = NUM_PERIPH_CLK,
  parameter int W = PRESCALER_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic hold_reset,
  input wire logic src_run,
  input wire logic [4*NUM-1:0] periph_cfg,
  output logic [NUM-1:0] periph_tick
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // Map a 3-bit ratio code to a tap of the divider chain.
  function automatic logic [3:0] tap_of(input logic [2:0] sel);
    tap_of = {1'b0, sel} + 4'h1;
  endfunction

  assign next_count = count + {{(W-1){1'b0}}, 1'b1};

  // ************************************************************************
  // Divider chain
  // ************************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (clk_en) begin
      if (hold_reset) begin
        count <= '0;
      end else if (src_run) begin
        count <= next_count;
      end
    end
  end

  // ************************************************************************
  // Per-peripheral ratio selection and gate
  // ************************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      periph_tick <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < NUM; i++) begin
        periph_tick[i] <= src_run && !hold_reset && periph_cfg[4*i+3]
          && (next_count[tap_of(periph_cfg[4*i +: 3])] &&
          !count[tap_of(periph_cfg[4*i +: 3])]);
      end
    end
  end

endmodule

/* clk_ctrl_props.sv */
// Concurrent assertions on the ports of the clock control block.
`timescale 1ns/100ps
module clk_ctrl_props
  import clk_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic sleep_mode,
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic slow_osc_en,
  input wire logic fast_osc_en,
  input wire logic cpu_clk_src_sel,
  input wire logic feedback_res_off,
  input wire logic [NUM_PERIPH_CLK-1:0] periph_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic key_open;
  wire logic wr_key = clk_en && wr && addr == PROTECT_KEY_ADDR;
  wire logic rd_key = clk_en && rd && addr == PROTECT_KEY_ADDR;
  wire logic wr_prot = clk_en && wr &&
    (addr == POWER_CONTROL_ADDR || addr == CLOCK_OPTION_ADDR);
  // ********************
  // Key tracking and assertions.
  // ********************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key_open <= 1'b0;
    end else if (wr_key) begin
      key_open <= wdata == PROTECT_UNLOCK_KEY;
    end else if (wr_prot) begin
      key_open <= 1'b0;
    end
  end
  property p_lock;
    wr_prot && !key_open && !sleep_mode |=> ##1 $stable(fast_osc_en) &&
      $stable(slow_osc_en) && $stable(cpu_clk_src_sel);
  endproperty
  property p_clear;
    wr_prot ##1 rd_key |=> rdata == PROTECT_KEY_RESET;
  endproperty
  property p_key_rd;
    wr_key ##1 rd_key |=> rdata == $past(wdata, 2);
  endproperty
  property p_fb;
    clk_en && wr && addr == LOW_SPEED_OSC_CONTROL_ADDR |-> ##2
      feedback_res_off == $past(wdata[FEEDBACK_RES_OFF_BIT], 2);
  endproperty
  property p_rst;
    $rose(arst_n) |-> cpu_clk_src_sel && fast_osc_en && slow_osc_en &&
      !feedback_res_off;
  endproperty
  property p_cpu_osc;
    (!sleep_mode) [*3] |-> (!cpu_clk_src_sel || fast_osc_en) &&
      (cpu_clk_src_sel || slow_osc_en);
  endproperty
  property p_src;
    $changed(cpu_clk_src_sel) |-> $past(fast_osc_en) && $past(slow_osc_en);
  endproperty
  property p_fast_off;
    (!fast_osc_en) [*2] |-> !(|periph_tick);
  endproperty
  property p_slow;
    (!cpu_clk_src_sel) [*2] |-> !(|periph_tick);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked write changed the oscillator outputs");
  a_clear: assert property (p_clear)
    else $error("key not cleared after protected write");
  a_key_rd: assert property (p_key_rd)
    else $error("key readback differs from written value");
  a_fb: assert property (p_fb)
    else $error("feedback resistor output wrong");
  a_rst: assert property (p_rst)
    else $error("wrong control levels after reset");
  a_cpu_osc: assert property (p_cpu_osc)
    else $error("oscillator feeding the cpu stopped");
  a_src: assert property (p_src)
    else $error("cpu clock source changed with an oscillator off");
  a_fast_off: assert property (p_fast_off)
    else $error("peripheral tick with fast oscillator off");
  a_slow: assert property (p_slow)
    else $error("peripheral tick with slow cpu clock");
  c_unlock: cover property (wr_key ##1 wr_prot);
  c_tick: cover property (|periph_tick);
  c_src: cover property ($changed(cpu_clk_src_sel));
endmodule
bind clk_ctrl clk_ctrl_props clk_ctrl_props_i (.clk(clk), .arst_n(arst_n),
  .clk_en(clk_en), .sleep_mode(sleep_mode), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .slow_osc_en(slow_osc_en),
  .fast_osc_en(fast_osc_en), .cpu_clk_src_sel(cpu_clk_src_sel),
  .feedback_res_off(feedback_res_off), .periph_tick(periph_tick));

/* clk_ctrl_tb.sv */
// Self-checking testbench for the clock control block.
`timescale 1ns/100ps
module clk_ctrl_tb
  import clk_ctrl_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic cold_start = 1'b0;
  logic sleep_mode = 1'b0;
  logic slow_oscillator = 1'b0;
  logic dram_read_strobe_n = 1'b1;
  logic port_data = 1'b0;
  logic [19:0] addr = 20'h0_0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic shared_output_pin, slow_osc_en, fast_osc_en;
  logic cpu_clk_src_sel, feedback_res_off;
  logic [NUM_PERIPH_CLK-1:0] periph_tick;
  int n_mismatch = 0;
  int comparisons = 0;
  always #25 clk = ~clk;
  clk_ctrl clk_ctrl_i (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .cold_start(cold_start), .sleep_mode(sleep_mode),
    .slow_oscillator(slow_oscillator),
    .dram_read_strobe_n(dram_read_strobe_n), .port_data(port_data),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .shared_output_pin(shared_output_pin), .slow_osc_en(slow_osc_en),
    .fast_osc_en(fast_osc_en), .cpu_clk_src_sel(cpu_clk_src_sel),
    .feedback_res_off(feedback_res_off), .periph_tick(periph_tick));
  // ********************
  // Bus and compare tasks.
  // ********************
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
  endtask
  task automatic prot(input logic [19:0] a, input logic [7:0] d);
    wr_reg(PROTECT_KEY_ADDR, PROTECT_UNLOCK_KEY);
    wr_reg(a, d);
  endtask
  task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read data", exp, rdata);
  endtask
  task automatic settle();
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic cold);
    @(posedge clk);
    arst_n <= 1'b0;
    cold_start <= cold;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    cold_start <= 1'b0;
  endtask
  task automatic count_ticks(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (40) begin
      @(posedge clk);
      #1;
      n = n + {7'h00, periph_tick[0]};
    end
    chk("tick count", exp, n);
  endtask
  task automatic follow(input int src);
    for (int v = 0; v < 2; v++) begin
      slow_oscillator <= v[0] ^ (src != 0);
      port_data <= v[0] ^ (src != 1);
      dram_read_strobe_n <= v[0] ^ (src != 2);
      settle();
      chk("shared pin", v[7:0], {7'h00, shared_output_pin});
    end
  endtask
  // ********************
  // Scenarios.
  // ********************
  task automatic t_regs();
    rd_chk(PROTECT_KEY_ADDR, PROTECT_KEY_RESET);
    rd_chk(POWER_CONTROL_ADDR, POWER_CONTROL_RESET);
    rd_chk(CLOCK_OPTION_ADDR, CLOCK_OPTION_RESET);
    rd_chk(LOW_SPEED_OSC_CONTROL_ADDR, LOW_SPEED_OSC_RESET);
    rd_chk(20'h4_0141, 8'h00);
    wr_reg(PROTECT_KEY_ADDR, 8'h5a);
    rd_chk(PROTECT_KEY_ADDR, 8'h5a);
    wr_reg(POWER_CONTROL_ADDR, 8'h00);
    wr_reg(CLOCK_OPTION_ADDR, 8'h01);
    rd_chk(POWER_CONTROL_ADDR, POWER_CONTROL_RESET);
    rd_chk(CLOCK_OPTION_ADDR, CLOCK_OPTION_RESET);
    prot(CLOCK_OPTION_ADDR, 8'h01);
    rd_chk(PROTECT_KEY_ADDR, 8'h00);
    wr_reg(CLOCK_OPTION_ADDR, 8'h00);
    rd_chk(CLOCK_OPTION_ADDR, 8'h01);
    wr_reg(LOW_SPEED_OSC_CONTROL_ADDR, 8'h02);
    settle();
    chk("feedback", 8'h01, {7'h00, feedback_res_off});
    rd_chk(LOW_SPEED_OSC_CONTROL_ADDR, 8'h03);
    wr_reg(LOW_SPEED_OSC_CONTROL_ADDR, 8'h00);
    settle();
    chk("feedback", 8'h00, {7'h00, feedback_res_off});
  endtask
  task automatic t_pins();
    wr_reg(OUTPUT_PIN_FUNCTION_SELECT_ADDR, 8'h02);
    wr_reg(PORT_FUNCTION_EXTENSION_ADDR, 8'h00);
    rd_chk(OUTPUT_PIN_FUNCTION_SELECT_ADDR, 8'h00);
    follow(0);
    prot(CLOCK_OPTION_ADDR, 8'h00);
    slow_oscillator <= 1'b1;
    settle();
    chk("pin disabled", 8'h00, {7'h00, shared_output_pin});
    slow_oscillator <= 1'b0;
    settle();
    chk("pin disabled", 8'h00, {7'h00, shared_output_pin});
    wr_reg(OUTPUT_PIN_FUNCTION_SELECT_ADDR, 8'h00);
    follow(1);
    wr_reg(OUTPUT_PIN_FUNCTION_SELECT_ADDR, 8'h02);
    wr_reg(PORT_FUNCTION_EXTENSION_ADDR, 8'h04);
    follow(2);
    do_reset(1'b0);
    wr_reg(LOW_SPEED_OSC_CONTROL_ADDR, 8'h02);
    follow(2);
    chk("feedback", 8'h01, {7'h00, feedback_res_off});
    wr_reg(PORT_FUNCTION_EXTENSION_ADDR, 8'h00);
    prot(CLOCK_OPTION_ADDR, 8'h01);
    follow(0);
    wr_reg(PORT_FUNCTION_EXTENSION_ADDR, 8'h04);
    settle();
    do_reset(1'b1);
    follow(1);
  endtask
  task automatic t_osc();
    wr_reg(PERIPH_CLK_BASE_ADDR, 8'h08);
    settle();
    count_ticks(8'h0a);
    prot(POWER_CONTROL_ADDR, 8'h25);
    rd_chk(POWER_CONTROL_ADDR, 8'h27);
    prot(POWER_CONTROL_ADDR, 8'h23);
    rd_chk(POWER_CONTROL_ADDR, 8'h23);
    count_ticks(8'h00);
    prot(POWER_CONTROL_ADDR, 8'h22);
    rd_chk(POWER_CONTROL_ADDR, 8'h23);
    prot(POWER_CONTROL_ADDR, 8'h21);
    settle();
    chk("fast osc", 8'h00, {7'h00, fast_osc_en});
    prot(POWER_CONTROL_ADDR, 8'h27);
    rd_chk(POWER_CONTROL_ADDR, 8'h23);
    repeat (20) @(posedge clk);
    prot(POWER_CONTROL_ADDR, 8'h27);
    rd_chk(POWER_CONTROL_ADDR, 8'h27);
    prot(POWER_CONTROL_ADDR, 8'h07);
    settle();
    count_ticks(8'h00);
    prot(POWER_CONTROL_ADDR, 8'h27);
    prot(CLOCK_OPTION_ADDR, 8'h04);
    rd_chk(CLOCK_OPTION_ADDR, 8'h04);
    sleep_mode <= 1'b1;
    settle();
    count_ticks(8'h00);
    chk("fast osc", 8'h00, {7'h00, fast_osc_en});
    sleep_mode <= 1'b0;
  endtask
  // ********************
  // Run control.
  // ********************
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // The tests need well under a thousand cycles.
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    do_reset(1'b1);
    t_regs();
    t_pins();
    t_osc();
    end_sim();
  end
endmodule
